// ==== inc/csmc_map.vh ====
// Register map, field layout, reset values and timing counts of the clock source mode control
`ifndef CSMC_MAP_VH
`define CSMC_MAP_VH

// ==================================================
// Register offsets
`define CSMC_ADDR_W            4
`define CSMC_OFF_CTRL1         4'h0
`define CSMC_OFF_CTRL2         4'h1
`define CSMC_OFF_STATUS        4'h2

// ==================================================
// Control register 1 fields
`define CSMC_C1_SRC_HI         7
`define CSMC_C1_SRC_LO         6
`define CSMC_C1_REFDIV_HI      5
`define CSMC_C1_REFDIV_LO      3
`define CSMC_C1_REFSEL         2
`define CSMC_C1_IROUT_EN       1
`define CSMC_C1_IRSTEN         0
`define CSMC_C1_RESET          8'h04

// ==================================================
// Control register 2 fields
`define CSMC_C2_LOWPWR         0
`define CSMC_C2_EROUT_EN       1
`define CSMC_C2_ERSTEN         2
`define CSMC_C2_BUSDIV_HI      4
`define CSMC_C2_BUSDIV_LO      3
`define CSMC_C2_RESET          8'h08

// ==================================================
// Source field encodings
`define CSMC_SRC_LOOP          2'h0
`define CSMC_SRC_INT           2'h1
`define CSMC_SRC_EXT           2'h2
`define CSMC_SRC_RSVD          2'h3

// ==================================================
// Mode codes shown in the status register
`define CSMC_MODE_LEI          3'h0
`define CSMC_MODE_LEE          3'h1
`define CSMC_MODE_BPI          3'h2
`define CSMC_MODE_BPILOW       3'h3
`define CSMC_MODE_BPE          3'h4
`define CSMC_MODE_BPELOW       3'h5
`define CSMC_MODE_STOP         3'h6

// ==================================================
// Timing
`define CSMC_LOOP_MULT         1024
`define CSMC_RELOCK_EDGES      3'h3

`endif

// ==== logic/csmc_sync.v ====
// Two-flop synchroniser for asynchronous clock levels
`timescale 1ns/1ps
module csmc_sync #(
  parameter WIDTH = 3
) (
  input  wire             clock_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule // csmc_sync

// ==== logic/csmc_top.v ====
// Clock source mode control: register file, source selection, dividers and stop gating
`timescale 1ns/1ps
`include "csmc_map.vh"
module csmc_top (
  input  wire                   clock_i,
  input  wire                   rst_b_i,
  input  wire [`CSMC_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wr_data_i,
  input  wire                   wr_stb_i,
  input  wire                   rd_stb_i,
  output wire [7:0]             rd_data_o,
  input  wire                   loop_clk_i,
  input  wire                   int_ref_clk_i,
  input  wire                   ext_ref_clk_i,
  input  wire                   stop_req_i,
  input  wire                   debug_mode_i,
  output wire                   output_clock_o,
  output wire                   bus_clock_o,
  output wire                   divided_ref_o,
  output wire                   loop_debug_clock_o,
  output wire                   internal_ref_out_clock_o,
  output wire                   external_ref_out_clock_o,
  output wire                   loop_enable_o,
  output wire                   int_ref_enable_o,
  output wire                   ext_ref_enable_o,
  output wire [2:0]             mode_o,
  output wire                   reference_status_o
);

  // ==================================================
  // Switch state machine
  localparam [1:0] ST_RUN    = 2'h0;
  localparam [1:0] ST_PARK   = 2'h1;
  localparam [1:0] ST_ENGAGE = 2'h2;

  // ==================================================
  // Functions
  // Follows the sampled clock but may only stop on a low level, never cutting a high phase
  function gate;
    input smp;
    input cur;
    input blk;
    begin
      gate = smp & (cur | ~blk);
    end
  endfunction

  // Power-of-two tap out of a free edge counter; tap 0 is the base clock itself
  function tap;
    input       base;
    input [6:0] cnt;
    input [2:0] sel;
    begin
      if (sel == 3'h0) begin
        tap = base;
      end else begin
        tap = cnt[sel-3'h1];
      end
    end
  endfunction

  // ==================================================
  // Synchronised clock levels
  wire [2:0] clk_s;
  wire       loop_s = clk_s[0];
  wire       int_s  = clk_s[1];
  wire       ext_s  = clk_s[2];

  csmc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .async_i ({ext_ref_clk_i, int_ref_clk_i, loop_clk_i}),
    .sync_o  (clk_s)
  );

  // ==================================================
  // Registers
  reg  [7:0] ctrl1_q;
  reg  [7:0] ctrl2_q;
  reg  [7:0] rd_data_q;

  wire [1:0] src_raw   = ctrl1_q[`CSMC_C1_SRC_HI:`CSMC_C1_SRC_LO];
  wire [2:0] ref_div   = ctrl1_q[`CSMC_C1_REFDIV_HI:`CSMC_C1_REFDIV_LO];
  wire       ref_sel   = ctrl1_q[`CSMC_C1_REFSEL];
  wire       ir_out_en = ctrl1_q[`CSMC_C1_IROUT_EN];
  wire       irsten    = ctrl1_q[`CSMC_C1_IRSTEN];
  wire       low_power = ctrl2_q[`CSMC_C2_LOWPWR];
  wire       er_out_en = ctrl2_q[`CSMC_C2_EROUT_EN];
  wire       ersten    = ctrl2_q[`CSMC_C2_ERSTEN];
  wire [1:0] bus_div   = ctrl2_q[`CSMC_C2_BUSDIV_HI:`CSMC_C2_BUSDIV_LO];

  wire [1:0] src_want  = (src_raw == `CSMC_SRC_RSVD) ? `CSMC_SRC_LOOP : src_raw;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl1_q <= `CSMC_C1_RESET;
      ctrl2_q <= `CSMC_C2_RESET;
    end else if (wr_stb_i) begin
      if (addr_i == `CSMC_OFF_CTRL1) begin
        ctrl1_q <= wr_data_i;
      end
      if (addr_i == `CSMC_OFF_CTRL2) begin
        ctrl2_q <= {3'h0, wr_data_i[4:0]};
      end
    end
  end

  // ==================================================
  // Mode decode
  reg  [2:0] mode_q;
  reg  [2:0] mode_d;
  reg  [2:0] prestop_mode_q;
  wire       low_pwr_ok = low_power & ~debug_mode_i;

  always @* begin
    mode_d = `CSMC_MODE_LEI;
    if (stop_req_i) begin
      mode_d = `CSMC_MODE_STOP;
    end else begin
      case (src_want)
        `CSMC_SRC_INT: begin
          mode_d = low_pwr_ok ? `CSMC_MODE_BPILOW : `CSMC_MODE_BPI;
        end
        `CSMC_SRC_EXT: begin
          mode_d = low_pwr_ok ? `CSMC_MODE_BPELOW : `CSMC_MODE_BPE;
        end
        default: begin
          mode_d = ref_sel ? `CSMC_MODE_LEI : `CSMC_MODE_LEE;
        end
      endcase
    end
  end

  wire was_int_mode = (prestop_mode_q == `CSMC_MODE_LEI) | (prestop_mode_q == `CSMC_MODE_BPI) |
                      (prestop_mode_q == `CSMC_MODE_BPILOW);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q         <= `CSMC_MODE_LEI;
      prestop_mode_q <= `CSMC_MODE_LEI;
    end else begin
      mode_q <= mode_d;
      if (!stop_req_i) begin
        prestop_mode_q <= mode_d;
      end
    end
  end

  // ==================================================
  // Source enables
  reg  loop_en_q;
  reg  int_en_q;
  reg  ext_en_q;
  wire stopped = (mode_q == `CSMC_MODE_STOP);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loop_en_q <= 1'b1;
      int_en_q  <= 1'b1;
      ext_en_q  <= 1'b0;
    end else begin
      // loop off in low power bypass
      loop_en_q <= ~stop_req_i & (mode_d != `CSMC_MODE_BPELOW) & (mode_d != `CSMC_MODE_BPILOW);
      int_en_q  <= stop_req_i ? (irsten & (ir_out_en | was_int_mode))
                              : (ref_sel | ir_out_en | (src_want == `CSMC_SRC_INT));
      ext_en_q  <= stop_req_i ? (er_out_en & ersten)
                              : (~ref_sel | er_out_en | (src_want == `CSMC_SRC_EXT));
    end
  end

  // ==================================================
  // Reference divider
  reg  [6:0] ref_cnt_q;
  reg        ref_last_q;
  reg        div_ref_q;
  wire       ref_s    = ref_sel ? int_s : ext_s;
  wire       ref_rise = ref_s & ~ref_last_q;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_cnt_q  <= 7'h00;
      ref_last_q <= 1'b0;
      div_ref_q  <= 1'b0;
    end else begin
      ref_last_q <= ref_s;
      if (ref_rise) begin
        ref_cnt_q <= ref_cnt_q + 7'h01;
      end
      // divide by two to the field
      div_ref_q <= gate(tap(ref_s, ref_cnt_q, ref_div), div_ref_q, stop_req_i);
    end
  end

  // ==================================================
  // Reference switch tracking
  reg        ref_stat_q;
  reg  [2:0] relock_q;
  reg        div_last_q;
  wire       div_rise = div_ref_q & ~div_last_q;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_stat_q <= 1'b1;
      relock_q   <= 3'h0;
      div_last_q <= 1'b0;
    end else begin
      div_last_q <= div_ref_q;
      if (ref_stat_q == ref_sel) begin
        relock_q <= 3'h0;
      end else if (div_rise) begin
        if (relock_q == `CSMC_RELOCK_EDGES - 3'h1) begin
          ref_stat_q <= ref_sel;
          relock_q   <= 3'h0;
        end else begin
          relock_q <= relock_q + 3'h1;
        end
      end
    end
  end

  // ==================================================
  // Output clock source switch
  reg  [1:0] state_q;
  reg  [1:0] cur_src_q;
  reg        out_clk_q;
  reg        src_smp;
  reg        new_smp;

  always @* begin
    case (cur_src_q)
      `CSMC_SRC_INT: src_smp = int_s;
      `CSMC_SRC_EXT: src_smp = ext_s;
      default:       src_smp = loop_s;
    endcase
    case (src_want)
      `CSMC_SRC_INT: new_smp = int_s;
      `CSMC_SRC_EXT: new_smp = ext_s;
      default:       new_smp = loop_s;
    endcase
  end

  wire switching = (state_q != ST_RUN) | (cur_src_q != src_want);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= ST_RUN;
      cur_src_q <= `CSMC_SRC_LOOP;
      out_clk_q <= 1'b0;
    end else begin
      out_clk_q <= gate(src_smp, out_clk_q, switching | stop_req_i);
      case (state_q)
        ST_RUN: begin
          if (cur_src_q != src_want) begin
            state_q <= ST_PARK;
          end
        end
        ST_PARK: begin
          if (!out_clk_q && !src_smp) begin
            state_q <= ST_ENGAGE;
          end
        end
        ST_ENGAGE: begin
          if (!new_smp) begin
            cur_src_q <= src_want;
            state_q   <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ==================================================
  // Bus divider and derived outputs
  reg  [6:0] bus_cnt_q;
  reg        out_last_q;
  reg        bus_clk_q;
  reg        dbg_clk_q;
  reg        irclk_q;
  reg        erclk_q;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_cnt_q  <= 7'h00;
      out_last_q <= 1'b0;
      bus_clk_q  <= 1'b0;
      dbg_clk_q  <= 1'b0;
      irclk_q    <= 1'b0;
      erclk_q    <= 1'b0;
    end else begin
      out_last_q <= out_clk_q;
      if (out_clk_q && !out_last_q) begin
        bus_cnt_q <= bus_cnt_q + 7'h01;
      end
      bus_clk_q <= gate(tap(out_clk_q, bus_cnt_q, {1'b0, bus_div}), bus_clk_q, stop_req_i);
      dbg_clk_q <= gate(loop_s, dbg_clk_q, ~loop_en_q | stop_req_i);
      irclk_q   <= gate(int_s, irclk_q, ~ir_out_en | ~int_en_q | (stop_req_i & ~irsten));
      erclk_q   <= gate(ext_s, erclk_q, ~er_out_en | ~ext_en_q | (stop_req_i & ~ersten));
    end
  end

  // ==================================================
  // Read port
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_q <= 8'h00;
    end else if (rd_stb_i) begin
      case (addr_i)
        `CSMC_OFF_CTRL1:  rd_data_q <= ctrl1_q;
        `CSMC_OFF_CTRL2:  rd_data_q <= ctrl2_q;
        `CSMC_OFF_STATUS: rd_data_q <= {switching, stopped, cur_src_q, ref_stat_q, mode_q};
        default:          rd_data_q <= 8'h00;
      endcase
    end else begin
      // Data stand only in the cycle after the strobe
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data_o                = rd_data_q;
  assign output_clock_o           = out_clk_q;
  assign bus_clock_o              = bus_clk_q;
  assign divided_ref_o            = div_ref_q;
  assign loop_debug_clock_o       = dbg_clk_q;
  assign internal_ref_out_clock_o = irclk_q;
  assign external_ref_out_clock_o = erclk_q;
  assign loop_enable_o            = loop_en_q;
  assign int_ref_enable_o         = int_en_q;
  assign ext_ref_enable_o         = ext_en_q;
  assign mode_o                   = mode_q;
  assign reference_status_o       = ref_stat_q;

endmodule // csmc_top

// ==== test/csmc_chk_sva.sv ====
// Concurrent checks on the clock source mode control ports
`timescale 1ns/1ps
`include "csmc_map.vh"
module csmc_chk (
  input wire       clock_i,
  input wire       rst_b_i,
  input wire [3:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire       wr_stb_i,
  input wire       stop_req_i,
  input wire       debug_mode_i,
  input wire       output_clock_o,
  input wire       bus_clock_o,
  input wire       loop_debug_clock_o,
  input wire       internal_ref_out_clock_o,
  input wire       external_ref_out_clock_o,
  input wire       loop_enable_o,
  input wire       int_ref_enable_o,
  input wire       ext_ref_enable_o,
  input wire [2:0] mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ==========
  // Shadow of the control registers
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c1_q <= `CSMC_C1_RESET;
      c2_q <= `CSMC_C2_RESET;
    end else if (wr_stb_i && addr_i == `CSMC_OFF_CTRL1) begin
      c1_q <= wr_data_i;
    end else if (wr_stb_i && addr_i == `CSMC_OFF_CTRL2) begin
      c2_q <= wr_data_i & 8'h1f;
    end
  end
  wire ext_cfg = c1_q[7:6] == `CSMC_SRC_EXT && !c1_q[2] && !stop_req_i;
  wire ir_off  = stop_req_i && !c1_q[0];
  wire er_off  = stop_req_i && !(c2_q[1] && c2_q[2]);
  // ==========
  // Mode sequences; gated outputs get 16 cycles to finish a high phase
  sequence s_bpe;    (ext_cfg && (debug_mode_i || !c2_q[0]))[*3]; endsequence
  sequence s_bpelow; (ext_cfg && !debug_mode_i && c2_q[0])[*3]; endsequence
  sequence s_stop;  stop_req_i[*8] ##1 stop_req_i[*8]; endsequence
  sequence s_ir;    ir_off[*8] ##1 ir_off[*8]; endsequence
  sequence s_er;    er_off[*8] ##1 er_off[*8]; endsequence
  sequence s_irc;   (!c1_q[1])[*8] ##1 (!c1_q[1])[*8]; endsequence
  // ==========
  // Assertions
  a_rsvd_as_loop: assert property (
    (c1_q[7:6] == `CSMC_SRC_RSVD && c1_q[2] && !stop_req_i)[*3] |-> mode_o == `CSMC_MODE_LEI)
    else $error("reserved source not acting as loop");
  a_bpe_entry: assert property (
    s_bpe |-> mode_o == `CSMC_MODE_BPE && loop_enable_o && ext_ref_enable_o)
    else $error("bypassed external mode wrong");
  a_bpelow_entry: assert property (
    s_bpelow |-> mode_o == `CSMC_MODE_BPELOW && !loop_enable_o && ext_ref_enable_o)
    else $error("bypassed external low power mode wrong");
  a_stop_entry: assert property (stop_req_i[*3] |-> mode_o == `CSMC_MODE_STOP)
    else $error("stop mode not entered");
  a_stop_static: assert property (
    s_stop |-> $stable(output_clock_o) && $stable(bus_clock_o) && !loop_debug_clock_o)
    else $error("clock moved in stop");
  a_irout_off: assert property (s_irc |-> !internal_ref_out_clock_o)
    else $error("internal out clock without enable");
  a_stop_irout: assert property (s_ir |-> !internal_ref_out_clock_o)
    else $error("internal out clock ran in stop");
  a_stop_erout: assert property (s_er |-> !external_ref_out_clock_o)
    else $error("external out clock ran in stop");
  a_stop_irdis: assert property (ir_off[*3] |-> !int_ref_enable_o)
    else $error("internal reference kept in stop");
endmodule // csmc_chk

// ==== test/csmc_ref_model.sv ====
// Free-running loop and reference clock sources for the bench
`timescale 1ns/1ps
module csmc_ref_model #(
  parameter int LOOP_HALF = 3,
  parameter int INT_HALF  = 5,
  parameter int EXT_HALF  = 7
) (
  input  wire  clock_i,
  output logic loop_clk_o,
  output logic int_ref_clk_o,
  output logic ext_ref_clk_o
);
  int         cnt_q [3] = '{0, 0, 0};
  logic [2:0] clk_q     = 3'h0;
  // fixed rates keep each divided reference in one band
  always @(posedge clock_i) begin
    for (int i = 0; i < 3; i++) begin
      if (cnt_q[i] == (i == 0 ? LOOP_HALF : i == 1 ? INT_HALF : EXT_HALF) - 1) begin
        cnt_q[i] <= 0;
        clk_q[i] <= ~clk_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 1;
      end
    end
  end
  assign {ext_ref_clk_o, int_ref_clk_o, loop_clk_o} = clk_q;
endmodule // csmc_ref_model

// ==== test/csmc_top_tb.sv ====
// Self-checking bench for the clock source mode control
`timescale 1ns/1ps
`include "csmc_map.vh"
module csmc_top_tb;
  logic       clock_i      = 1'b0;
  logic       rst_b_i      = 1'b0;
  logic [3:0] addr_i       = 4'h0;
  logic [7:0] wr_data_i    = 8'h00;
  logic       wr_stb_i     = 1'b0;
  logic       rd_stb_i     = 1'b0;
  logic       stop_req_i   = 1'b0;
  logic       debug_mode_i = 1'b0;
  wire  [7:0] rd_data_o;
  wire  [5:0] mon;
  wire  [2:0] rclk;
  wire  [2:0] mode_o;
  wire        loop_en;
  wire        ext_en;
  wire        int_en;
  wire        ref_st;
  int         n_mismatch   = 0;
  int         comparisons  = 0;
  int         cyc          = 0;

  always #4 clock_i = ~clock_i;

  csmc_ref_model u_csmc_ref_model (.clock_i(clock_i), .loop_clk_o(rclk[0]), .int_ref_clk_o(rclk[1]),
    .ext_ref_clk_o(rclk[2]));
  csmc_top u_csmc_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .loop_clk_i(rclk[0]),
    .int_ref_clk_i(rclk[1]), .ext_ref_clk_i(rclk[2]), .stop_req_i(stop_req_i),
    .debug_mode_i(debug_mode_i), .output_clock_o(mon[0]), .bus_clock_o(mon[1]), .divided_ref_o(mon[2]),
    .loop_debug_clock_o(mon[3]), .internal_ref_out_clock_o(mon[4]), .external_ref_out_clock_o(mon[5]),
    .loop_enable_o(loop_en), .int_ref_enable_o(int_en), .ext_ref_enable_o(ext_en), .mode_o(mode_o),
    .reference_status_o(ref_st));

  // ==========
  // Shared tasks
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_stb_i  <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clock_i);
    rd_stb_i <= 1'b1;
    addr_i   <= a;
    @(posedge clock_i);
    rd_stb_i <= 1'b0;
    #1 chk(nm, e, rd_data_o);
  endtask
  // Settle, then count rising edges over a whole number of periods
  task automatic ec(input int w, input int win, input int e, input string nm);
    int   n;
    logic p;
    n = 0;
    repeat (120) @(posedge clock_i);
    #1 p = mon[w];
    repeat (win) begin
      @(posedge clock_i);
      #1 if (mon[w] && !p) n++;
      p = mon[w];
    end
    chk(nm, e[7:0], n[7:0]);
  endtask

  // ==========
  // Scenarios
  task automatic t_regs;
    rd(4'h0, 8'h04, "ctrl1 reset");
    rd(4'h1, 8'h08, "ctrl2 reset");
    rd(4'h2, 8'h08, "status reset");
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00, "unmapped");
    rd(4'h0, 8'h04, "ctrl1 kept");
  endtask
  task automatic t_src;
    logic [7:0] cfg [4] = '{8'h04, 8'h44, 8'h80, 8'hc4};
    int         edg [4] = '{35, 21, 15, 35};
    logic [2:0] md  [4] = '{`CSMC_MODE_LEI, `CSMC_MODE_BPI, `CSMC_MODE_BPE, `CSMC_MODE_LEI};
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, cfg[i]);
      ec(0, 210, edg[i], "output clock");
      chk("source mode", {5'h00, md[i]}, {5'h00, mode_o});
    end
  endtask
  task automatic t_div;
    for (int k = 0; k < 5; k++) begin
      wr(4'h0, {2'h0, k[2:0], 3'h4});
      ec(2, 160, 16 >> k, "divided ref");
    end
    wr(4'h0, 8'h00);
    ec(2, 210, 15, "divided ext ref");
    chk("ref status", 8'h00, {7'h00, ref_st});
    chk("loop ext mode", {5'h00, `CSMC_MODE_LEE}, {5'h00, mode_o});
    wr(4'h0, 8'h04);
  endtask
  task automatic t_bus;
    for (int b = 0; b < 4; b++) begin
      wr(4'h1, {3'h0, b[1:0], 3'h0});
      ec(1, 240, 40 >> b, "bus clock");
    end
    wr(4'h1, 8'h08);
  endtask
  task automatic t_lp;
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h09);
    ec(3, 210, 0, "debug clock low power");
    chk("low power mode", {5'h00, `CSMC_MODE_BPELOW}, {5'h00, mode_o});
    chk("low power enables", 8'h01, {6'h00, loop_en, ext_en});
    // Debug session overrides low power
    @(posedge clock_i);
    debug_mode_i <= 1'b1;
    ec(3, 210, 35, "debug clock bypass");
    chk("bypass mode", {5'h00, `CSMC_MODE_BPE}, {5'h00, mode_o});
    chk("bypass enables", 8'h03, {6'h00, loop_en, ext_en});
    @(posedge clock_i);
    debug_mode_i <= 1'b0;
    wr(4'h0, 8'h44);
    ec(0, 210, 21, "output clock internal low power");
    chk("internal low power mode", {5'h00, `CSMC_MODE_BPILOW}, {4'h0, loop_en, mode_o});
    wr(4'h1, 8'h08);
  endtask
  task automatic t_stop;
    wr(4'h0, 8'h07);
    wr(4'h1, 8'h0e);
    stop_req_i <= 1'b1;
    ec(4, 210, 21, "ir out stop");
    ec(5, 210, 15, "er out stop");
    ec(0, 210, 0, "output clock stop");
    chk("stop mode", {5'h00, `CSMC_MODE_STOP}, {5'h00, mode_o});
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h0a);
    ec(4, 210, 0, "ir out stop off");
    ec(5, 210, 0, "er out stop off");
    chk("int ref enable", 8'h00, {7'h00, int_en});
    @(posedge clock_i);
    stop_req_i <= 1'b0;
    ec(4, 210, 21, "ir out run");
    wr(4'h0, 8'h04);
    ec(4, 210, 0, "ir out off");
    // Kept in stop by the pre-stop mode alone
    wr(4'h0, 8'h05);
    stop_req_i <= 1'b1;
    ec(4, 210, 0, "ir out stop no enable");
    chk("int ref kept in stop", 8'h01, {7'h00, int_en});
    @(posedge clock_i);
    stop_req_i <= 1'b0;
    wr(4'h0, 8'h01);
    repeat (8) @(posedge clock_i);
    stop_req_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    #1 chk("int ref dropped in stop", 8'h00, {7'h00, int_en});
    @(posedge clock_i);
    stop_req_i <= 1'b0;
    wr(4'h0, 8'h04);
  endtask

  // ==========
  // Sequence and hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_src();
    t_div();
    t_bus();
    t_lp();
    t_stop();
    close_out();
  end
endmodule // csmc_top_tb

bind csmc_top csmc_chk u_csmc_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .stop_req_i(stop_req_i), .debug_mode_i(debug_mode_i),
  .output_clock_o(output_clock_o), .bus_clock_o(bus_clock_o), .loop_debug_clock_o(loop_debug_clock_o),
  .internal_ref_out_clock_o(internal_ref_out_clock_o), .external_ref_out_clock_o(external_ref_out_clock_o),
  .loop_enable_o(loop_enable_o), .int_ref_enable_o(int_ref_enable_o), .ext_ref_enable_o(ext_ref_enable_o),
  .mode_o(mode_o));
